// >>> hw/fsr_fault_status.sv
// fault status register bank with off-state open-load detection
`timescale 1ns/10ps
module fsr_fault_status #(
    parameter int FILTER_CYCLES = fsr_pkg::FILTER_CYC
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic chip_select_n,
    input wire fsr_pkg::fsr_write_s regWrite,
    input wire logic regReadValid,
    input wire logic [fsr_pkg::ADDR_W-1:0] regReadAddr,
    input wire logic sleepMode,
    input wire logic [fsr_pkg::NUM_PRE-1:0] outputOn,
    input wire logic [fsr_pkg::NUM_PRE-1:0] openCompare,
    input wire logic [fsr_pkg::NUM_PRE-1:0] overcurrentRaw,
    input wire logic watchdogEnable,
    input wire logic [6:0] watchdogTimer,
    input wire fsr_pkg::fsr_cond_s condRaw,
    input wire logic [7:0] onOffState,
    output logic [fsr_pkg::DATA_W-1:0] readData,
    output logic readValid,
    output logic [fsr_pkg::NUM_PRE-1:0] pullDownEnable
);
    localparam int NP = fsr_pkg::NUM_PRE;
    localparam int DW = fsr_pkg::DATA_W;

    // chip select comes from a pin, so it is synchronised before use;
    // it is carried as a selected level so that the synchroniser's reset
    // value matches an idle pin and no false release follows reset
    logic csSync;
    logic csPrev;
    logic csRise;
    fsr_sync3 #(.WIDTH(1)) csSyncInst (
        .clk(clk),
        .rst_n(rst_n),
        .din(!chip_select_n),
        .dout(csSync)
    );
    assign csRise = !csSync && csPrev; // release of chip select

    // one detector per predriver output
    logic [NP-1:0] openDetect;
    genvar g;
    generate
        for (g = 0; g < NP; g++) begin : gDet
            fsr_open_load #(.FILTER_CYCLES(FILTER_CYCLES)) detInst (
                .clk(clk),
                .rst_n(rst_n),
                .outputOn(outputOn[g]),
                .pullDownEnable(pullDownEnable[g]),
                .openCompare(openCompare[g]),
                .chipSelectRise(csRise),
                .openDetect(openDetect[g])
            );
        end
    endgenerate

    // a latched flag sets on its condition; a write of zero clears only if gone
    function automatic logic latchFlag(
        input logic cur,
        input logic cond,
        input logic wrZero
    );
        logic res;
        res = cur;
        if (wrZero && !cond) begin
            res = 1'b0;
        end
        if (cond) begin
            res = 1'b1;
        end
        return res;
    endfunction

    // latched state
    logic [NP-1:0] openFlag;
    logic [NP-1:0] overFlag;
    logic [NP-1:0] preAny;
    logic condOtFlag;
    logic [3:0] supFlag;
    logic supAny;
    logic pullDownWrite;
    logic [NP-1:0] pullDownData;
    logic [NP-1:0] next_openFlag;
    logic [NP-1:0] next_overFlag;
    logic [NP-1:0] next_preAny;
    logic next_condOtFlag;
    logic [3:0] next_supFlag;
    logic next_supAny;
    logic [NP-1:0] next_pullDownEnable;
    logic [3:0] supRaw;
    logic [DW-1:0] next_readData;
    logic [DW-1:0] wrData;
    logic wrOk;

    // pull-down control: no register for it is mapped, so its host write is tied off with the data held at all ones
    assign pullDownWrite = 1'b0;
    assign pullDownData = '1;
    assign wrOk = regWrite.valid;
    assign wrData = regWrite.data;
    assign supRaw = {condRaw.spiError, condRaw.vprotShortBattery,
                     condRaw.vprotOverTemp, condRaw.vprotShortGround};

    // next values of all latched flags
    always_comb begin
        logic wz;
        logic [3:0] supCond;
        wz = 1'b0;
        supCond = supRaw;
        for (int i = 0; i < NP; i++) begin
            wz = wrOk && (regWrite.addr == fsr_pkg::ADDR_HEATER + 4'(i));
            // a disabled pull-down forces the open-load bit to zero
            if (!pullDownEnable[i]) begin
                next_openFlag[i] = 1'b0;
            end else begin
                // stays latched after the load returns, until host clears
                next_openFlag[i] = latchFlag(openFlag[i], openDetect[i],
                    wz && !wrData[fsr_pkg::BIT_OPEN]);
            end
            next_overFlag[i] = latchFlag(overFlag[i], overcurrentRaw[i],
                wz && !wrData[fsr_pkg::BIT_OVER]);
            // summary clears only when every summarized condition is gone
            if (openDetect[i] || overcurrentRaw[i] || next_openFlag[i] || next_overFlag[i]) begin
                next_preAny[i] = 1'b1;
            end else if (wz && !wrData[fsr_pkg::BIT_ANY]) begin
                next_preAny[i] = 1'b0;
            end else begin
                next_preAny[i] = preAny[i];
            end
            // pull-down drops only in sleep; the host write branch is tied off
            if (sleepMode) begin
                next_pullDownEnable[i] = 1'b0;
            end else if (pullDownWrite) begin
                next_pullDownEnable[i] = pullDownData[i];
            end else begin
                next_pullDownEnable[i] = pullDownEnable[i];
            end
        end
        wz = wrOk && (regWrite.addr == fsr_pkg::ADDR_COND);
        next_condOtFlag = latchFlag(condOtFlag, condRaw.isoOverTemp,
            wz && !wrData[fsr_pkg::BIT_COND_OT]);
        wz = wrOk && (regWrite.addr == fsr_pkg::ADDR_SUPPLY);
        for (int j = 0; j < 4; j++) begin
            next_supFlag[j] = latchFlag(supFlag[j], supCond[j], wz && !wrData[j]);
        end
        if ((|supCond) || (|next_supFlag) || (|next_preAny) || next_condOtFlag) begin
            next_supAny = 1'b1;
        end else if (wz && !wrData[fsr_pkg::BIT_ANY]) begin
            next_supAny = 1'b0;
        end else begin
            next_supAny = supAny;
        end
    end

    // read multiplexer, registered
    always_comb begin
        next_readData = fsr_pkg::READ_ZERO;
        if (regReadAddr == fsr_pkg::ADDR_HEATER ||
            regReadAddr == fsr_pkg::ADDR_IGN_ONE ||
            regReadAddr == fsr_pkg::ADDR_IGN_TWO) begin
            for (int k = 0; k < NP; k++) begin
                if (regReadAddr == fsr_pkg::ADDR_HEATER + 4'(k)) begin
                    next_readData[fsr_pkg::BIT_ANY] = preAny[k];
                    next_readData[fsr_pkg::BIT_OPEN] = openFlag[k];
                    next_readData[fsr_pkg::BIT_OVER] = overFlag[k];
                end
            end
        end else if (regReadAddr == fsr_pkg::ADDR_WDOG) begin
            next_readData = {watchdogEnable, watchdogTimer};
        end else if (regReadAddr == fsr_pkg::ADDR_COND) begin
            next_readData = {condRaw.peak, 1'b0, condRaw.clampPos, condRaw.clampNeg,
                             condOtFlag};
        end else if (regReadAddr == fsr_pkg::ADDR_SUPPLY) begin
            next_readData = {supAny, condRaw.keySwitch, condRaw.powerEnable,
                             condRaw.batterySwitch, supFlag};
        end else if (regReadAddr == fsr_pkg::ADDR_ONOFF) begin
            next_readData = onOffState;
        end else if (regReadAddr == fsr_pkg::ADDR_MODEL) begin
            next_readData = {fsr_pkg::MODEL_CODE, fsr_pkg::REV_CODE};
        end else begin
            next_readData = fsr_pkg::READ_ZERO; // unmapped reads as zero
        end
    end

    // registers; pull-downs come up enabled
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            csPrev <= 1'b0;
            openFlag <= '0;
            overFlag <= '0;
            preAny <= '0;
            condOtFlag <= 1'b0;
            supFlag <= '0;
            supAny <= 1'b0;
            pullDownEnable <= '1;
            readData <= fsr_pkg::READ_ZERO;
            readValid <= 1'b0;
        end else begin
            csPrev <= csSync;
            openFlag <= next_openFlag;
            overFlag <= next_overFlag;
            preAny <= next_preAny;
            condOtFlag <= next_condOtFlag;
            supFlag <= next_supFlag;
            supAny <= next_supAny;
            pullDownEnable <= next_pullDownEnable;
            readData <= next_readData;
            readValid <= regReadValid;
        end
    end
endmodule // fsr_fault_status

// >>> hw/fsr_pkg.sv
// package: register map, field layout, timing constants and carrier types of the fault status bank
package fsr_pkg;
    localparam int ADDR_W = 4;
    localparam int DATA_W = 8;
    localparam int NUM_PRE = 3;
    // register addresses
    localparam logic [3:0] ADDR_HEATER = 4'h7;
    localparam logic [3:0] ADDR_IGN_ONE = 4'h8;
    localparam logic [3:0] ADDR_IGN_TWO = 4'h9;
    localparam logic [3:0] ADDR_WDOG = 4'hA;
    localparam logic [3:0] ADDR_COND = 4'hB;
    localparam logic [3:0] ADDR_SUPPLY = 4'hD;
    localparam logic [3:0] ADDR_ONOFF = 4'hE;
    localparam logic [3:0] ADDR_MODEL = 4'hF;
    // field positions
    localparam int BIT_ANY = 7;
    localparam int BIT_OPEN = 3;
    localparam int BIT_OVER = 2;
    localparam int BIT_WD_EN = 7;
    localparam int BIT_COND_OT = 0;
    localparam int BIT_SUP_SPI = 3;
    localparam int BIT_SUP_VBAT = 2;
    localparam int BIT_SUP_VOT = 1;
    localparam int BIT_SUP_VGND = 0;
    // arbitrary neutral identity values
    localparam logic [2:0] MODEL_CODE = 3'h1;
    localparam logic [4:0] REV_CODE = 5'h01;
    localparam logic [7:0] READ_ZERO = 8'h00;
    // filter timing: 100 to 450 us window, the target is placed at the middle
    localparam int CLK_MHZ = 125;
    localparam int FILTER_MIN_US = 100;
    localparam int FILTER_MAX_US = 450;
    localparam int FILTER_CYC = ((FILTER_MIN_US + FILTER_MAX_US) / 2) * CLK_MHZ;
    // register write request from the serial interface
    typedef struct packed {
        logic valid;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
    } fsr_write_s;
    // raw condition inputs from the supply and conditioner blocks
    typedef struct packed {
        logic [3:0] peak;
        logic clampPos;
        logic clampNeg;
        logic isoOverTemp;
        logic keySwitch;
        logic powerEnable;
        logic batterySwitch;
        logic spiError;
        logic vprotShortBattery;
        logic vprotOverTemp;
        logic vprotShortGround;
    } fsr_cond_s;
endpackage

// >>> hw/fsr_sync3.sv
// three-stage pin synchroniser with agreement of the last two stages
`timescale 1ns/10ps
module fsr_sync3 #(
    parameter int WIDTH = 1
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [WIDTH-1:0] din,
    output logic [WIDTH-1:0] dout
);
    logic [WIDTH-1:0] stageA;
    logic [WIDTH-1:0] stageB;
    logic [WIDTH-1:0] stageC;
    logic [WIDTH-1:0] next_dout;

    // a bit only changes once the second and third stages agree
    always_comb begin
        for (int i = 0; i < WIDTH; i++) begin
            next_dout[i] = (stageB[i] == stageC[i]) ? stageC[i] : dout[i];
        end
    end

    // stageA is read by stageB only
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            stageA <= '0;
            stageB <= '0;
            stageC <= '0;
            dout <= '0;
        end else begin
            stageA <= din;
            stageB <= stageA;
            stageC <= stageB;
            dout <= next_dout;
        end
    end
endmodule // fsr_sync3

// >>> hw/fsr_open_load.sv
// off-state open-load detector for one predriver output
`timescale 1ns/10ps
module fsr_open_load #(
    parameter int FILTER_CYCLES = fsr_pkg::FILTER_CYC
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic outputOn,
    input wire logic pullDownEnable,
    input wire logic openCompare,
    input wire logic chipSelectRise,
    output logic openDetect
);
    localparam int CNT_W = $clog2(FILTER_CYCLES + 1);
    localparam logic [CNT_W-1:0] CNT_MAX = CNT_W'(FILTER_CYCLES);
    logic [CNT_W-1:0] delayCount;
    logic [CNT_W-1:0] next_delayCount;
    logic next_openDetect;
    logic armed;

    // delay timer restarts on chip select release and on any switching or pull-down change
    always_comb begin
        armed = (delayCount == CNT_MAX);
        if (chipSelectRise || outputOn || !pullDownEnable) begin
            next_delayCount = '0;
        end else if (!armed) begin
            next_delayCount = delayCount + CNT_W'(1);
        end else begin
            next_delayCount = delayCount;
        end
        // comparator only looked at when off, pulled down, and timed out
        next_openDetect = armed && !outputOn && pullDownEnable && openCompare;
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            delayCount <= '0;
            openDetect <= 1'b0;
        end else begin
            delayCount <= next_delayCount;
            openDetect <= next_openDetect;
        end
    end
endmodule // fsr_open_load

// >>> testbench/fsr_fault_status_checker.sv
// concurrent checks on the fault status bank ports
`timescale 1ns/10ps
module fsr_fault_status_checker #(
    parameter int FILTER_CYCLES = fsr_pkg::FILTER_CYC
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic sleepMode,
    input wire logic regReadValid,
    input wire logic [fsr_pkg::ADDR_W-1:0] regReadAddr,
    input wire logic watchdogEnable,
    input wire logic [6:0] watchdogTimer,
    input wire logic [fsr_pkg::DATA_W-1:0] readData,
    input wire logic readValid,
    input wire logic [fsr_pkg::NUM_PRE-1:0] pullDownEnable
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);
    // read of one address, read of a predriver register, pull-downs held off
    sequence rd_at(logic [3:0] a);
        regReadValid && regReadAddr == a;
    endsequence
    sequence rd_pre;
        regReadValid && regReadAddr inside {[4'h7:4'h9]};
    endsequence
    sequence pd_off;
        (pullDownEnable == 3'h0) [*2];
    endsequence
    read_answer_a: assert property (regReadValid |=> readValid)
        else $error("read gave no answer");
    read_pulse_a: assert property (!regReadValid |=> !readValid)
        else $error("answer without a read");
    pd_reset_a: assert property ($rose(rst_n) |-> pullDownEnable == 3'h7)
        else $error("pull-downs off after reset");
    pd_sleep_a: assert property ((sleepMode) [*3] |-> pullDownEnable == 3'h0)
        else $error("pull-down on in sleep");
    pd_hold_a: assert property (!sleepMode && pullDownEnable == 3'h7 |=>
        pullDownEnable == 3'h7)
        else $error("pull-down dropped on its own");
    open_off_a: assert property (pd_off ##0 rd_pre |=> !readData[3])
        else $error("open flag with pull-down off");
    wd_view_a: assert property (rd_at(fsr_pkg::ADDR_WDOG) |=>
        readData == {$past(watchdogEnable), $past(watchdogTimer)})
        else $error("watchdog view wrong");
    pre_zero_a: assert property (rd_pre |=> readData[6:4] == 3'h0 && readData[1:0] == 2'h0)
        else $error("reserved bits set");
endmodule // fsr_fault_status_checker
bind fsr_fault_status fsr_fault_status_checker #(.FILTER_CYCLES(FILTER_CYCLES)) chk (
    .clk(clk), .rst_n(rst_n), .sleepMode(sleepMode), .regReadValid(regReadValid),
    .regReadAddr(regReadAddr), .watchdogEnable(watchdogEnable),
    .watchdogTimer(watchdogTimer), .readData(readData), .readValid(readValid),
    .pullDownEnable(pullDownEnable));

// >>> testbench/fsr_host_model.sv
// host model issuing register reads, writes and chip select frames
`timescale 1ns/10ps
module fsr_host_model (
    input wire logic clk,
    input wire logic [7:0] readData,
    input wire logic readValid,
    output logic chip_select_n,
    output fsr_pkg::fsr_write_s regWrite,
    output logic regReadValid,
    output logic [3:0] regReadAddr
);
    // idle bus at time zero
    initial begin
        chip_select_n = 1'b1;
        regWrite = '0;
        regReadValid = 1'b0;
        regReadAddr = 4'h0;
    end
    // one-cycle read; a released address shows its inverse, not the old value
    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        @(negedge clk);
        regReadValid = 1'b1;
        regReadAddr = a;
        @(negedge clk);
        regReadValid = 1'b0;
        regReadAddr = ~a;
        d = (readValid === 1'b1) ? readData : 8'hEE; // late answer shows as mismatch
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] v);
        @(negedge clk);
        regWrite = '{1'b1, a, v};
        @(negedge clk);
        regWrite = '{1'b0, ~a, ~v};
    endtask
    // a frame held low long enough to pass the pin filter; its closing edge restarts the timer
    task automatic cs_pulse();
        @(negedge clk);
        chip_select_n = 1'b0;
        repeat (4) @(negedge clk);
        chip_select_n = 1'b1;
    endtask
endmodule // fsr_host_model

// >>> testbench/fault_status_registers_bench.sv
// self-checking bench of the fault status register bank
`timescale 1ns/10ps
module fault_status_registers_bench;
    localparam int FILT = 20;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic sleepMode = 1'b0;
    logic [2:0] outputOn = 3'h0;
    logic [2:0] openCompare = 3'h0;
    logic [2:0] overcurrentRaw = 3'h0;
    logic watchdogEnable = 1'b0;
    logic [6:0] watchdogTimer = 7'h00;
    logic [7:0] onOffState = 8'h00;
    logic chip_select_n, regReadValid, readValid;
    logic [3:0] regReadAddr, a;
    logic [7:0] readData, rd;
    logic [2:0] pullDownEnable;
    logic [31:0] seed = 32'h0000005C;
    logic [31:0] r;
    fsr_pkg::fsr_write_s regWrite;
    fsr_pkg::fsr_cond_s condRaw = '0; // supply and conditioner faults idle except in the latch test
    int err_total = 0;
    int num_checks = 0;
    always #4 clk = ~clk;
    fsr_fault_status #(.FILTER_CYCLES(FILT)) dut (.clk(clk), .rst_n(rst_n),
        .chip_select_n(chip_select_n), .regWrite(regWrite), .regReadValid(regReadValid),
        .regReadAddr(regReadAddr), .sleepMode(sleepMode), .outputOn(outputOn),
        .openCompare(openCompare), .overcurrentRaw(overcurrentRaw),
        .watchdogEnable(watchdogEnable), .watchdogTimer(watchdogTimer), .condRaw(condRaw),
        .onOffState(onOffState), .readData(readData), .readValid(readValid),
        .pullDownEnable(pullDownEnable));
    fsr_host_model host (.clk(clk), .readData(readData), .readValid(readValid),
        .chip_select_n(chip_select_n), .regWrite(regWrite), .regReadValid(regReadValid),
        .regReadAddr(regReadAddr));
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    // predriver register image: summary, open load, overcurrent
    function automatic logic [7:0] pre(logic any, logic open, logic over);
        return {any, 3'h0, open, over, 2'h0};
    endfunction
    task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wait_cyc(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic wr_rd(input logic [3:0] ad, input logic [7:0] v);
        host.wr(ad, v);
        host.rd(ad, rd);
    endtask
    task automatic end_sim();
        if (err_total == 0 && num_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    // a few hundred cycles are needed; about sixteen times that means a hang
    initial begin
        #40000;
        err_total++;
        end_sim();
    end
    initial begin
        wait_cyc(2);
        rst_n = 1'b1;
        wait_cyc(4);
        cmp8({5'h00, pullDownEnable}, 8'h07);
        for (int i = 7; i < 10; i++) begin
            host.rd(i[3:0], rd);
            cmp8(rd, pre(1'b0, 1'b0, 1'b0));
        end
        // random watchdog values; writes to the read-only view must not stick
        repeat (8) begin
            r = xs();
            {watchdogEnable, watchdogTimer, onOffState} = r[15:0];
            wr_rd(fsr_pkg::ADDR_WDOG, ~{watchdogEnable, watchdogTimer});
            cmp8(rd, {watchdogEnable, watchdogTimer});
        end
        // overcurrent latch, refused and accepted write-zero clears
        for (int i = 0; i < 3; i++) begin
            a = fsr_pkg::ADDR_HEATER + 4'(i);
            overcurrentRaw[i] = 1'b1;
            wait_cyc(6);
            wr_rd(a, 8'h00);
            cmp8(rd, pre(1'b1, 1'b0, 1'b1));
            overcurrentRaw[i] = 1'b0;
            wait_cyc(6);
            wr_rd(a, 8'h04);
            cmp8(rd, pre(1'b1, 1'b0, 1'b1));
            wr_rd(a, 8'h80);
            cmp8(rd, pre(1'b1, 1'b0, 1'b0));
            wr_rd(a, 8'h00);
            cmp8(rd, pre(1'b0, 1'b0, 1'b0));
        end
        // supply and conditioner latches: refused while active, cleared once gone
        condRaw.vprotOverTemp = 1'b1;
        condRaw.isoOverTemp = 1'b1;
        wait_cyc(4);
        host.wr(fsr_pkg::ADDR_COND, 8'h00);
        wr_rd(fsr_pkg::ADDR_SUPPLY, 8'h00);
        cmp8(rd, 8'h82);
        host.rd(fsr_pkg::ADDR_COND, rd);
        cmp8(rd, 8'h01);
        condRaw.vprotOverTemp = 1'b0;
        condRaw.isoOverTemp = 1'b0;
        wait_cyc(2);
        wr_rd(fsr_pkg::ADDR_COND, 8'h00);
        cmp8(rd, 8'h00);
        wr_rd(fsr_pkg::ADDR_SUPPLY, 8'h80);
        cmp8(rd, 8'h80);
        wr_rd(fsr_pkg::ADDR_SUPPLY, 8'h00);
        cmp8(rd, 8'h00);
        // open load after switch-off: filtered, then latched past its cause
        outputOn = 3'h1;
        openCompare = 3'h1;
        wait_cyc(4);
        outputOn = 3'h0;
        // release chip select before the filter runs out: the timer must start over
        wait_cyc(FILT - 12);
        host.cs_pulse();
        wait_cyc(10);
        host.rd(fsr_pkg::ADDR_HEATER, rd);
        cmp8(rd, pre(1'b0, 1'b0, 1'b0));
        wait_cyc(FILT + 8);
        host.rd(fsr_pkg::ADDR_HEATER, rd);
        cmp8(rd, pre(1'b1, 1'b1, 1'b0));
        openCompare = 3'h0;
        wait_cyc(4);
        host.rd(fsr_pkg::ADDR_HEATER, rd);
        cmp8(rd, pre(1'b1, 1'b1, 1'b0));
        wr_rd(fsr_pkg::ADDR_HEATER, 8'h00);
        cmp8(rd, pre(1'b0, 1'b0, 1'b0));
        // output commanded on: comparator must be ignored
        outputOn = 3'h1;
        openCompare = 3'h1;
        host.cs_pulse();
        wait_cyc(FILT + 10);
        host.rd(fsr_pkg::ADDR_HEATER, rd);
        cmp8(rd, pre(1'b0, 1'b0, 1'b0));
        outputOn = 3'h0;
        host.cs_pulse();
        wait_cyc(FILT + 10);
        host.rd(fsr_pkg::ADDR_HEATER, rd);
        cmp8(rd, pre(1'b1, 1'b1, 1'b0));
        cmp8({5'h00, pullDownEnable}, 8'h07);
        // sleep drops the pull-downs and hides the open flag
        sleepMode = 1'b1;
        wait_cyc(4);
        cmp8({5'h00, pullDownEnable}, 8'h00);
        host.rd(fsr_pkg::ADDR_HEATER, rd);
        cmp8(rd & 8'h08, 8'h00);
        sleepMode = 1'b0;
        wait_cyc(4);
        end_sim();
    end
endmodule // fault_status_registers_bench
